/* File: hdl/tccsr_pkg.sv */
// Package: word addresses, codes and field values of the trigger control and status register bank
package tccsr_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;
  localparam logic [15:0] ADDR_FAULT_CODE = 16'h0064;
  localparam logic [15:0] ADDR_FLASH_CNT_LO = 16'h0066;
  localparam logic [15:0] ADDR_FLASH_CNT_HI = 16'h0067;
  localparam logic [15:0] ADDR_ENC0_LO = 16'h006e;
  localparam logic [15:0] ADDR_ENC0_HI = 16'h006f;
  localparam logic [15:0] ADDR_ENC1_LO = 16'h0072;
  localparam logic [15:0] ADDR_ENC1_HI = 16'h0073;
  localparam logic [15:0] ADDR_ARM_REQ = 16'h0078;
  localparam logic [15:0] ADDR_DISARM_REQ = 16'h0079;
  localparam logic [15:0] ADDR_CFG_STATE = 16'h007a;
  localparam logic [15:0] ADDR_CAP_STATE = 16'h007b;
  localparam logic [15:0] ADDR_ACQ_FLAG = 16'h007c;
  // Logging areas, first word of each, last word of area B and of the conversion area
  localparam logic [15:0] ADDR_CLOG_A_FIRST = 16'h3aac;
  localparam logic [15:0] ADDR_CLOG_B_FIRST = 16'h4eac;
  localparam logic [15:0] ADDR_CLOG_B_LAST = 16'h62ab;
  localparam logic [15:0] ADDR_CONV_FIRST = 16'h7530;
  localparam logic [15:0] ADDR_CONV_LAST = 16'hb52f;
  localparam logic [15:0] REQ_NONE = 16'h0000;
  localparam logic [15:0] REQ_ACTIVE = 16'h0001;
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_ARM_NO_SETTING = 16'h10c0;
  localparam logic [15:0] ERR_ARM_SIMULATION = 16'h10c1;
  localparam logic [1:0] CFG_NONE = 2'h0;
  localparam logic [1:0] CFG_MANUAL = 2'h1;
  localparam logic [1:0] CFG_AUTO = 2'h2;
  localparam int unsigned ENC_W = 32;
  localparam int unsigned ENC_LEN_W = 6;
  localparam logic [5:0] ENC_LEN_MAX = 6'h20;
  localparam int unsigned LOG_WORDS = 16;
  localparam int unsigned LOG_AW = 4;
  typedef enum logic [0:0] {TCCSR_STOPPED, TCCSR_READY} tccsr_cap_state_t;
endpackage : tccsr_pkg

/* File: hdl/tccsr_log_if.sv */
// Interface: write and read port of the logging storage memory
interface tccsr_log_if;
  import tccsr_pkg::*;
  logic wr_en;
  logic [LOG_AW-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [LOG_AW-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : tccsr_log_if

/* File: hdl/tccsr_log_mem.sv */
// Logging storage memory with registered read data
module tccsr_log_mem
  import tccsr_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Memory port
  tccsr_log_if.mem port
);
  logic [DATA_W-1:0] mem_ff [LOG_WORDS];
  logic [DATA_W-1:0] rd_data_ff;

  // Every word comes up as zero after power-on or controller reset
  genvar i;
  generate
    for (i = 0; i < LOG_WORDS; i++) begin : g_word
      always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          mem_ff[i] <= '0;
        end else if (port.wr_en && port.wr_addr == LOG_AW'(i)) begin
          mem_ff[i] <= port.wr_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_data_ff <= '0;
    end else begin
      rd_data_ff <= mem_ff[port.rd_addr];
    end
  end

  assign port.rd_data = rd_data_ff;
endmodule : tccsr_log_mem

/* File: hdl/tccsr_regs.sv */
// Trigger control and status register bank with fault, flash counter and encoder capture words
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Latest fault code held, newest overwrites
// - Fault clear on request on-then-off
// - Flash logic write increments 32-bit counter
// - Encoder 0 frame captured without parity
// - Short frames right-aligned to bit 0
// - Encoder 1 captured the same way
// - Arm request moves trigger to ready
// - Arm request word auto-cleared after ready
// - Arm values other than 0/1 ignored
// - Arm without setting raises 10C0H
// - Arm during simulation raises 10C1H
// - Arm while ready stays ready
// - Disarm while ready enters stopped
// - Disarm request word auto-cleared after stop
// - Disarm values other than 0/1 ignored
// - Disarm while stopped stays stopped
// - Config state 0 none, 1 manual, 2 auto
// - Stored setting loaded at power-on
// - Logging storage zeroed at reset
// - Continuous logging A/B halves read-only
// - Conversion logging A/B buffers read-only
// - Trigger state reads 0 stopped, 1 ready
// - Arm 0-to-1 clears acquired flag
module tccsr_regs
  import tccsr_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  // Controller output signal
  input wire logic fault_clear_request_in,
  // Module events and status
  input wire logic fault_event_in,
  input wire logic [DATA_W-1:0] fault_code_in,
  input wire logic flash_logic_write_in,
  input wire logic logic_running_in,
  input wire logic simulation_in,
  input wire logic setting_load_in,
  input wire logic [1:0] setting_kind_in,
  input wire logic setting_clear_in,
  input wire logic sample_done_in,
  // Stored setting seen at power-on
  input wire logic flash_setting_valid_in,
  input wire logic [1:0] flash_setting_kind_in,
  // Serial encoder frames
  input wire logic enc0_frame_in,
  input wire logic [ENC_W:0] enc0_bits_in,
  input wire logic [ENC_LEN_W-1:0] enc0_len_in,
  input wire logic enc1_frame_in,
  input wire logic [ENC_W:0] enc1_bits_in,
  input wire logic [ENC_LEN_W-1:0] enc1_len_in,
  // Logging writes from the acquisition side
  input wire logic log_wr_in,
  input wire logic [LOG_AW-1:0] log_waddr_in,
  input wire logic [DATA_W-1:0] log_wdata_in,
  // Status out
  output logic capture_ready_out,
  output logic sample_acquired_flag_out
);
  //////////////////////////////////////////////////////////////////////////////
  logic [DATA_W-1:0] fault_code_ff;
  logic [2*DATA_W-1:0] flash_cnt_ff;
  logic [ENC_W-1:0] enc_cap_ff [2];
  logic [DATA_W-1:0] arm_req_ff;
  logic [DATA_W-1:0] disarm_req_ff;
  logic [1:0] cfg_state_ff;
  tccsr_cap_state_t cap_state_ff;
  logic acq_flag_ff;
  logic clr_seen_ff;
  logic strap_done_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic log_sel_ff;
  logic [DATA_W-1:0] nxt_fault_code;
  logic [1:0] nxt_cfg_state;
  logic [DATA_W-1:0] nxt_arm_req;
  logic [DATA_W-1:0] nxt_disarm_req;
  tccsr_cap_state_t nxt_cap_state;
  logic nxt_acq_flag;

  tccsr_log_if log_bus ();

  tccsr_log_mem u_log_mem (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .port(log_bus.mem)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Decode
  wire wr_arm = reg_wr_in && reg_addr_in == ADDR_ARM_REQ;
  wire wr_disarm = reg_wr_in && reg_addr_in == ADDR_DISARM_REQ;
  wire arm_pending = arm_req_ff == REQ_ACTIVE;
  wire disarm_pending = disarm_req_ff == REQ_ACTIVE;
  wire arm_fail_cfg = arm_pending && cfg_state_ff == CFG_NONE;
  wire arm_fail_sim = arm_pending && !arm_fail_cfg && simulation_in;
  wire arm_ok = arm_pending && !arm_fail_cfg && !simulation_in && logic_running_in;
  wire disarm_ok = disarm_pending && !arm_ok;
  wire clear_done = clr_seen_ff && !fault_clear_request_in;
  wire in_clog = reg_addr_in >= ADDR_CLOG_A_FIRST && reg_addr_in <= ADDR_CLOG_B_LAST;
  wire in_conv = reg_addr_in >= ADDR_CONV_FIRST && reg_addr_in <= ADDR_CONV_LAST;
  wire arm_rise = wr_arm && reg_wdata_in == REQ_ACTIVE && arm_req_ff == REQ_NONE;

  assign log_bus.wr_en = log_wr_in;
  assign log_bus.wr_addr = log_waddr_in;
  assign log_bus.wr_data = log_wdata_in;
  assign log_bus.rd_addr = reg_addr_in[LOG_AW-1:0];

  // Newest error wins over an earlier one and over a clear in the same cycle
  always_comb begin
    nxt_fault_code = fault_code_ff;
    if (clear_done) begin
      nxt_fault_code = ERR_NONE;
    end
    if (arm_fail_sim) begin
      nxt_fault_code = ERR_ARM_SIMULATION;
    end
    if (arm_fail_cfg) begin
      nxt_fault_code = ERR_ARM_NO_SETTING;
    end
    if (fault_event_in) begin
      nxt_fault_code = fault_code_in;
    end
  end

  always_comb begin
    nxt_cfg_state = cfg_state_ff;
    if (!strap_done_ff) begin
      nxt_cfg_state = flash_setting_valid_in ? flash_setting_kind_in : CFG_NONE;
    end else if (setting_clear_in) begin
      nxt_cfg_state = CFG_NONE;
    end else if (setting_load_in) begin
      nxt_cfg_state = setting_kind_in;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Fault word and clear handshake
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      fault_code_ff <= ERR_NONE;
    end else begin
      fault_code_ff <= nxt_fault_code;
    end
  end

  // Last sampled level of the clear signal; its fall completes the handshake
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      clr_seen_ff <= 1'b0;
    end else begin
      clr_seen_ff <= fault_clear_request_in;
    end
  end

  // Flash write counter; the part is only rated for a limited number of writes
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      flash_cnt_ff <= '0;
    end else if (flash_logic_write_in) begin
      flash_cnt_ff <= flash_cnt_ff + 32'h0000_0001;
    end
  end

  // Encoder captures: drop parity (bit 0 of the raw frame), keep only len bits
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_enc
      wire frame = ch == 0 ? enc0_frame_in : enc1_frame_in;
      wire [ENC_W:0] raw = ch == 0 ? enc0_bits_in : enc1_bits_in;
      wire [ENC_LEN_W-1:0] len = ch == 0 ? enc0_len_in : enc1_len_in;
      wire [ENC_W-1:0] data = raw[ENC_W:1];
      wire [ENC_W-1:0] mask = len >= ENC_LEN_MAX ? '1 : ~({ENC_W{1'b1}} << len);
      always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          enc_cap_ff[ch] <= '0;
        end else if (frame) begin
          enc_cap_ff[ch] <= data & mask;
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Request words, trigger state, acquired flag
  // An arm refused for no setting or for simulation also retires its request; an arm while logic is not running stays pending
  wire arm_retire = arm_ok || arm_fail_cfg || arm_fail_sim;
  wire set_stopped = disarm_ok || simulation_in || !logic_running_in || sample_done_in;
  wire acq_set = sample_done_in && cap_state_ff == TCCSR_READY;
  wire acq_clear = arm_rise || simulation_in;

  // A host write in the same cycle as the auto-clear wins, so no request is lost
  always_comb begin
    nxt_arm_req = arm_req_ff;
    if (wr_arm) begin
      nxt_arm_req = reg_wdata_in;
    end else if (arm_retire) begin
      nxt_arm_req = REQ_NONE;
    end
  end

  always_comb begin
    nxt_disarm_req = disarm_req_ff;
    if (wr_disarm) begin
      nxt_disarm_req = reg_wdata_in;
    end else if (disarm_ok) begin
      nxt_disarm_req = REQ_NONE;
    end
  end

  // Arm beats a same-cycle disarm or sample done; simulation or logic not running blocks the arm instead
  always_comb begin
    nxt_cap_state = cap_state_ff;
    if (arm_ok) begin
      nxt_cap_state = TCCSR_READY;
    end else if (set_stopped) begin
      nxt_cap_state = TCCSR_STOPPED;
    end
  end

  // Completion beats a same-cycle clear, so finished data is never hidden
  always_comb begin
    nxt_acq_flag = acq_flag_ff;
    if (acq_set) begin
      nxt_acq_flag = 1'b1;
    end else if (acq_clear) begin
      nxt_acq_flag = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      arm_req_ff <= REQ_NONE;
    end else begin
      arm_req_ff <= nxt_arm_req;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      disarm_req_ff <= REQ_NONE;
    end else begin
      disarm_req_ff <= nxt_disarm_req;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cap_state_ff <= TCCSR_STOPPED;
    end else begin
      cap_state_ff <= nxt_cap_state;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      acq_flag_ff <= 1'b0;
    end else begin
      acq_flag_ff <= nxt_acq_flag;
    end
  end

  // Setting state: stored setting is captured once, on the first edge after reset release
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cfg_state_ff <= CFG_NONE;
    end else begin
      cfg_state_ff <= nxt_cfg_state;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      strap_done_ff <= 1'b0;
    end else begin
      strap_done_ff <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read path; logging areas come from the memory in the same cycle as the register words, one cycle after the read
  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    unique case (reg_addr_in)
      ADDR_FAULT_CODE: rd_mux = fault_code_ff;
      ADDR_FLASH_CNT_LO: rd_mux = flash_cnt_ff[DATA_W-1:0];
      ADDR_FLASH_CNT_HI: rd_mux = flash_cnt_ff[2*DATA_W-1:DATA_W];
      ADDR_ENC0_LO: rd_mux = enc_cap_ff[0][DATA_W-1:0];
      ADDR_ENC0_HI: rd_mux = enc_cap_ff[0][ENC_W-1:DATA_W];
      ADDR_ENC1_LO: rd_mux = enc_cap_ff[1][DATA_W-1:0];
      ADDR_ENC1_HI: rd_mux = enc_cap_ff[1][ENC_W-1:DATA_W];
      ADDR_ARM_REQ: rd_mux = arm_req_ff;
      ADDR_DISARM_REQ: rd_mux = disarm_req_ff;
      ADDR_CFG_STATE: rd_mux = {14'h0000, cfg_state_ff};
      ADDR_CAP_STATE: rd_mux = {15'h0000, cap_state_ff == TCCSR_READY};
      ADDR_ACQ_FLAG: rd_mux = {15'h0000, acq_flag_ff};
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= reg_rd_in ? rd_mux : '0;
    end
  end

  // Remembers that the word of this read comes from the logging memory
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      log_sel_ff <= 1'b0;
    end else begin
      log_sel_ff <= reg_rd_in && (in_clog || in_conv);
    end
  end

  // Storage words beyond the small memory alias onto it
  assign reg_rdata_out = log_sel_ff ? log_bus.rd_data : rdata_ff;

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      capture_ready_out <= 1'b0;
    end else begin
      capture_ready_out <= cap_state_ff == TCCSR_READY;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sample_acquired_flag_out <= 1'b0;
    end else begin
      sample_acquired_flag_out <= acq_flag_ff;
    end
  end
endmodule : tccsr_regs

/* File: dv/tccsr_regs_chk.sv */
// Checker: port-level properties of the trigger control register bank
module tccsr_regs_chk
  import tccsr_pkg::*;
(
  // Clock, reset and register port
  input wire logic clk_in, rst_b_in, reg_wr_in, reg_rd_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in, reg_rdata_out,
  // Events and status
  input wire logic flash_logic_write_in, enc0_frame_in, enc1_frame_in, capture_ready_out,
  input wire logic [ENC_W:0] enc0_bits_in, enc1_bits_in,
  input wire logic [ENC_LEN_W-1:0] enc0_len_in, enc1_len_in
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  logic [31:0] e0_ff, e1_ff, cnt_ff;
  wire r_e0l = reg_rd_in && reg_addr_in == ADDR_ENC0_LO;
  wire r_e0h = reg_rd_in && reg_addr_in == ADDR_ENC0_HI;
  wire r_e1l = reg_rd_in && reg_addr_in == ADDR_ENC1_LO;
  wire r_e1h = reg_rd_in && reg_addr_in == ADDR_ENC1_HI;
  wire r_cl = reg_rd_in && reg_addr_in == ADDR_FLASH_CNT_LO;
  wire r_ch = reg_rd_in && reg_addr_in == ADDR_FLASH_CNT_HI;
  wire w_dis = reg_wr_in && reg_addr_in == ADDR_DISARM_REQ && reg_wdata_in == REQ_ACTIVE;
  // Only the configured frame length survives, parity at bit 0 is dropped
  function automatic logic [31:0] frm(logic [ENC_W:0] b, logic [ENC_LEN_W-1:0] n);
    return b[ENC_W:1] & (32'hffffffff >> (ENC_LEN_MAX - n));
  endfunction
  ////////////////////////////////////////
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      e0_ff <= 32'h0;
      e1_ff <= 32'h0;
      cnt_ff <= 32'h0;
    end else begin
      if (enc0_frame_in) e0_ff <= frm(enc0_bits_in, enc0_len_in);
      if (enc1_frame_in) e1_ff <= frm(enc1_bits_in, enc1_len_in);
      if (flash_logic_write_in) cnt_ff <= cnt_ff + 32'h1;
    end
  end
  ////////////////////////////////////////
  property p_e0l; r_e0l |=> reg_rdata_out == $past(e0_ff[15:0]); endproperty
  a_e0l: assert property (p_e0l) else $error("encoder 0 low word wrong");
  property p_e0h; r_e0h |=> reg_rdata_out == $past(e0_ff[31:16]); endproperty
  a_e0h: assert property (p_e0h) else $error("encoder 0 high word wrong");
  property p_e1l; r_e1l |=> reg_rdata_out == $past(e1_ff[15:0]); endproperty
  a_e1l: assert property (p_e1l) else $error("encoder 1 low word wrong");
  property p_e1h; r_e1h |=> reg_rdata_out == $past(e1_ff[31:16]); endproperty
  a_e1h: assert property (p_e1h) else $error("encoder 1 high word wrong");
  property p_cl; r_cl |=> reg_rdata_out == $past(cnt_ff[15:0]); endproperty
  a_cl: assert property (p_cl) else $error("flash count low word wrong");
  property p_ch; r_ch |=> reg_rdata_out == $past(cnt_ff[31:16]); endproperty
  a_ch: assert property (p_ch) else $error("flash count high word wrong");
  property p_dis; w_dis |-> ##[1:3] !capture_ready_out; endproperty
  a_dis: assert property (p_dis) else $error("disarm did not stop");
  property p_sys;
    reg_rd_in && reg_addr_in > ADDR_CLOG_B_LAST && reg_addr_in < ADDR_CONV_FIRST |=> reg_rdata_out == 16'h0;
  endproperty
  a_sys: assert property (p_sys) else $error("gap after logging area not zero");
  c_arm: cover property (reg_wr_in && reg_addr_in == ADDR_ARM_REQ);
  c_rdy: cover property ($rose(capture_ready_out));
  c_enc: cover property (enc0_frame_in ##[1:20] r_e0l);
endmodule // tccsr_regs_chk

bind tccsr_regs tccsr_regs_chk i_tccsr_regs_chk (.clk_in(clk_in), .rst_b_in(rst_b_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .flash_logic_write_in(flash_logic_write_in), .enc0_frame_in(enc0_frame_in), .enc1_frame_in(enc1_frame_in),
  .capture_ready_out(capture_ready_out), .enc0_bits_in(enc0_bits_in), .enc1_bits_in(enc1_bits_in),
  .enc0_len_in(enc0_len_in), .enc1_len_in(enc1_len_in));

/* File: dv/tccsr_cpu_model.sv */
// Controller CPU model: word reads, writes and the fault clear signal
module tccsr_cpu_model
  import tccsr_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Register port
  output logic [ADDR_W-1:0] addr_out,
  output logic [DATA_W-1:0] wdata_out,
  output logic wr_out,
  output logic rd_out,
  input wire logic [DATA_W-1:0] rdata_in,
  // Controller output signal
  output logic fault_clear_request_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    addr_out = 16'h0;
    wdata_out = 16'h0;
    wr_out = 1'b0;
    rd_out = 1'b0;
    fault_clear_request_out = 1'b0;
  end
  ////////////////////////////////////////
  // Released lines are inverted so a stale address never looks valid
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    @(posedge clk_in);
    d = rdata_in;
  endtask
  task automatic clear_fault();
    @(posedge clk_in);
    fault_clear_request_out <= 1'b1;
    repeat (2) @(posedge clk_in);
    fault_clear_request_out <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask
endmodule // tccsr_cpu_model

/* File: dv/tccsr_regs_tb.sv */
// Testbench of the trigger control register bank
module tccsr_regs_tb
  import tccsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_b = 1'b0, wr, rd, fclr, fev = 1'b0, fwr = 1'b0, run = 1'b0, sim = 1'b0;
  logic sload = 1'b0, sclr = 1'b0, sdone = 1'b0, e0f = 1'b0, e1f = 1'b0, lwr = 1'b0, cr, saf;
  logic [15:0] addr, wdata, rdata, fcode = 16'h0, lwd = 16'h0;
  logic [1:0] skind = 2'h0, fsk = 2'h2;
  logic fsv = 1'b1;
  logic [32:0] e0b = 33'h0, e1b = 33'h0;
  logic [5:0] e0l = 6'h1, e1l = 6'h1;
  logic [3:0] lwa = 4'h0;
  int fails = 0, compares = 0;
  always #10 clk = ~clk;
  tccsr_cpu_model i_tccsr_cpu_model (.clk_in(clk), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
    .rd_out(rd), .rdata_in(rdata), .fault_clear_request_out(fclr));
  tccsr_regs i_tccsr_regs (.clk_in(clk), .rst_b_in(rst_b), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .fault_clear_request_in(fclr), .fault_event_in(fev),
    .fault_code_in(fcode), .flash_logic_write_in(fwr), .logic_running_in(run), .simulation_in(sim),
    .setting_load_in(sload), .setting_kind_in(skind), .setting_clear_in(sclr), .sample_done_in(sdone),
    .flash_setting_valid_in(fsv), .flash_setting_kind_in(fsk), .enc0_frame_in(e0f), .enc0_bits_in(e0b),
    .enc0_len_in(e0l), .enc1_frame_in(e1f), .enc1_bits_in(e1b), .enc1_len_in(e1l), .log_wr_in(lwr),
    .log_waddr_in(lwa), .log_wdata_in(lwd), .capture_ready_out(cr), .sample_acquired_flag_out(saf));
  ////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] d;
    i_tccsr_cpu_model.rd(a, d);
    chk(d, exp);
  endtask
  task automatic w(input logic [15:0] a, input logic [15:0] d);
    i_tccsr_cpu_model.wr(a, d);
  endtask
  task automatic end_of_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  task automatic t_log();
    rc(ADDR_CFG_STATE, {14'h0, CFG_AUTO});
    rc(ADDR_CLOG_A_FIRST, 16'h0);
    @(posedge clk);
    lwr <= 1'b1;
    lwa <= 4'h5;
    lwd <= 16'hbeef;
    @(posedge clk);
    lwr <= 1'b0;
    w(ADDR_CLOG_A_FIRST + 16'h9, 16'h0);
    rc(ADDR_CLOG_A_FIRST + 16'h9, 16'hbeef);
    rc(ADDR_CONV_FIRST + 16'h5, 16'hbeef);
    rc(16'h62ac, 16'h0);
    // Controller reset in mid-run must wipe the logging words again
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    rc(ADDR_CONV_FIRST + 16'h5, 16'h0);
  endtask
  // Two back-to-back events: only the newer code may survive
  task automatic t_fault();
    @(posedge clk);
    fev <= 1'b1;
    fcode <= 16'h1234;
    @(posedge clk);
    fcode <= 16'h5678;
    @(posedge clk);
    fev <= 1'b0;
    rc(ADDR_FAULT_CODE, 16'h5678);
    i_tccsr_cpu_model.clear_fault();
    rc(ADDR_FAULT_CODE, ERR_NONE);
  endtask
  task automatic t_flash_enc();
    repeat (3) begin
      @(posedge clk);
      fwr <= 1'b1;
      @(posedge clk);
      fwr <= 1'b0;
    end
    rc(ADDR_FLASH_CNT_LO, 16'h3);
    rc(ADDR_FLASH_CNT_HI, 16'h0);
    @(posedge clk);
    e0b <= {20'hfffff, 12'hab5, 1'b1};
    e0l <= 6'hc;
    e1b <= {32'h89abcdef, 1'b0};
    e1l <= 6'h20;
    e0f <= 1'b1;
    e1f <= 1'b1;
    @(posedge clk);
    e0f <= 1'b0;
    e1f <= 1'b0;
    w(ADDR_ENC0_LO, 16'hffff);
    rc(ADDR_ENC0_LO, 16'h0ab5);
    rc(ADDR_ENC0_HI, 16'h0);
    rc(ADDR_ENC1_LO, 16'hcdef);
    rc(ADDR_ENC1_HI, 16'h89ab);
  endtask
  task automatic t_arm_err();
    @(posedge clk);
    sclr <= 1'b1;
    run <= 1'b1;
    @(posedge clk);
    sclr <= 1'b0;
    rc(ADDR_CFG_STATE, 16'h0);
    w(ADDR_ARM_REQ, REQ_ACTIVE);
    rc(ADDR_FAULT_CODE, ERR_ARM_NO_SETTING);
    rc(ADDR_CAP_STATE, 16'h0);
    @(posedge clk);
    sload <= 1'b1;
    skind <= CFG_MANUAL;
    sim <= 1'b1;
    @(posedge clk);
    sload <= 1'b0;
    rc(ADDR_CFG_STATE, 16'h1);
    w(ADDR_ARM_REQ, REQ_ACTIVE);
    rc(ADDR_FAULT_CODE, ERR_ARM_SIMULATION);
    chk({15'h0, cr}, 16'h0);
    @(posedge clk);
    sim <= 1'b0;
    w(ADDR_ARM_REQ, 16'h2);
    rc(ADDR_ARM_REQ, 16'h2);
    rc(ADDR_CAP_STATE, 16'h0);
  endtask
  task automatic t_arm();
    w(ADDR_ARM_REQ, REQ_NONE);
    w(ADDR_ARM_REQ, REQ_ACTIVE);
    rc(ADDR_CAP_STATE, 16'h1);
    rc(ADDR_ARM_REQ, REQ_NONE);
    @(posedge clk);
    sdone <= 1'b1;
    @(posedge clk);
    sdone <= 1'b0;
    rc(ADDR_ACQ_FLAG, 16'h1);
    chk({15'h0, saf}, 16'h1);
    w(ADDR_ARM_REQ, REQ_ACTIVE);
    rc(ADDR_ACQ_FLAG, 16'h0);
    w(ADDR_ARM_REQ, REQ_ACTIVE);
    repeat (3) @(posedge clk);
    chk({15'h0, cr}, 16'h1);
    w(ADDR_DISARM_REQ, 16'h3);
    rc(ADDR_DISARM_REQ, 16'h3);
    rc(ADDR_CAP_STATE, 16'h1);
    w(ADDR_DISARM_REQ, REQ_ACTIVE);
    rc(ADDR_CAP_STATE, 16'h0);
    rc(ADDR_DISARM_REQ, REQ_NONE);
    w(ADDR_DISARM_REQ, REQ_ACTIVE);
    rc(ADDR_CAP_STATE, 16'h0);
    chk({15'h0, saf}, 16'h0);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    t_log();
    t_fault();
    t_flash_enc();
    t_arm_err();
    t_arm();
    end_of_test();
  end
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    end_of_test();
  end
endmodule // tccsr_regs_tb
